// File: rtl/xbs_consts.vh
// Operation
// - The device drives address bits 0 through 15 on the sixteen shared lines during the address phase of every external cycle.
// - In the data phase eight or sixteen data bits move over the shared lines, as the cycle's bus width says.
// - The active-low address-valid strobe is asserted only for external accesses, marking a valid address on the lines.
// - The address-valid strobe stays low while the cycle runs and goes high as soon as the cycle completes.
// - The active-high address-latch strobe is asserted only in external cycles and marks the start of a cycle with a valid address.
// - The address-latch strobe does not go back high until a new external cycle is about to begin.
`ifndef XBS_CONSTS_VH
`define XBS_CONSTS_VH
`define XBS_AW          16
`define XBS_DW          16
`define XBS_CLK_MHZ     20
// least address phase and data phase lengths in ns
`define XBS_ADDR_NS     50
`define XBS_DATA_NS     100
`define XBS_ADDR_CYC    ((`XBS_ADDR_NS * `XBS_CLK_MHZ + 999) / 1000)
`define XBS_DATA_CYC    ((`XBS_DATA_NS * `XBS_CLK_MHZ + 999) / 1000)
`define XBS_ST_IDLE     3'h0
`define XBS_ST_ADDR     3'h1
`define XBS_ST_DATA     3'h2
`define XBS_ST_DONE     3'h3
`define XBS_CNT_W       4
`endif

// File: rtl/xbs_lane_mux.v
`timescale 1ns/10ps
`include "xbs_consts.vh"
module xbs_lane_mux
(
    // selection
    input  wire                  addr_phase,
    input  wire                  wide,
    input  wire                  high_only,
    // values
    input  wire [`XBS_AW-1:0]    addr,
    input  wire [`XBS_DW-1:0]    wdata,
    // result
    output reg  [`XBS_DW-1:0]    lines
);
    always @*
    begin
        if (addr_phase)
            lines = addr;
        else if (wide)
            lines = wdata;
        else if (high_only)
            lines = {8'h00, wdata[15:8]};
        else
            lines = {8'h00, wdata[7:0]};
    end
endmodule // xbs_lane_mux

// File: rtl/xbs_addr_strobes.v
`timescale 1ns/10ps
`include "xbs_consts.vh"
module xbs_addr_strobes
(
    // clock and reset
    input  wire                  sys_clk,
    input  wire                  rst_n,
    // core request
    input  wire                  req_valid,
    input  wire                  req_external,
    input  wire                  req_write,
    input  wire                  req_wide,
    input  wire [`XBS_AW-1:0]    req_addr,
    input  wire [`XBS_DW-1:0]    req_wdata,
    output reg                   req_ready,
    output reg                   rsp_valid,
    output reg  [`XBS_DW-1:0]    rsp_rdata,
    // bus width and wait from the pins
    input  wire                  bus_width_in,
    input  wire                  ready_in,
    // shared lines
    input  wire [`XBS_DW-1:0]    shared_addr_data_lines_in,
    output reg  [`XBS_DW-1:0]    shared_addr_data_lines_out,
    output reg                   shared_addr_data_lines_oe,
    // strobes
    output reg                   addr_valid_n,
    output reg                   addr_latch,
    output reg                   rd_n,
    output reg                   wr_n
);
    // cycle lengths follow the minimum phase times at the core clock rate
    localparam integer          ADDR_CYC_I = `XBS_ADDR_CYC;
    localparam integer          DATA_CYC_I = `XBS_DATA_CYC;
    localparam [`XBS_CNT_W-1:0] ADDR_CYC   = ADDR_CYC_I[`XBS_CNT_W-1:0];
    localparam [`XBS_CNT_W-1:0] DATA_CYC   = DATA_CYC_I[`XBS_CNT_W-1:0];
    localparam [`XBS_CNT_W-1:0] ADDR_LAST  = ADDR_CYC - 4'h1;
    localparam [`XBS_CNT_W-1:0] DATA_LAST  = DATA_CYC - 4'h1;

    // sequencer states
    localparam [2:0] ST_IDLE = `XBS_ST_IDLE;
    localparam [2:0] ST_ADDR = `XBS_ST_ADDR;
    localparam [2:0] ST_DATA = `XBS_ST_DATA;
    localparam [2:0] ST_DONE = `XBS_ST_DONE;

    reg  [2:0]            state_reg;
    reg  [`XBS_CNT_W-1:0] cnt_reg;
    reg                   write_reg;
    reg                   wide_reg;
    reg  [`XBS_AW-1:0]    addr_reg;
    reg  [`XBS_DW-1:0]    wdata_reg;
    wire [`XBS_DW-1:0]    lines_next;
    wire [`XBS_DW-1:0]    rdata_next;
    wire [`XBS_AW-1:0]    mux_addr;
    wire                  mux_wide;
    wire                  take_int;
    wire                  start;
    wire                  to_data;
    wire                  data_wait;
    wire                  data_end;
    wire                  addr_phase_next;

    // an internal access is answered at once and never touches the pins
    assign take_int  = (state_reg == ST_IDLE) && req_valid && !req_external;
    assign start     = (state_reg == ST_IDLE) && req_valid && req_external;
    assign to_data   = (state_reg == ST_ADDR) && (cnt_reg == ADDR_LAST);
    assign data_wait = (state_reg == ST_DATA) && (cnt_reg != DATA_LAST);
    assign data_end  = (state_reg == ST_DATA) && (cnt_reg == DATA_LAST) && ready_in;

    // the lane mux sees the phase about to be driven so the pins stay registered
    assign addr_phase_next = start || ((state_reg == ST_ADDR) && !to_data);
    assign mux_addr        = start ? req_addr : addr_reg;
    // the width pin only counts as the data phase opens, so it is folded in here
    assign mux_wide        = wide_reg & bus_width_in;

    xbs_lane_mux u_mux
    (
        .addr_phase (addr_phase_next),
        .wide       (mux_wide),
        .high_only  (addr_reg[0]),
        .addr       (mux_addr),
        .wdata      (wdata_reg),
        .lines      (lines_next)
    );

    // a byte read on an odd address arrives on the upper lane
    assign rdata_next = wide_reg    ? shared_addr_data_lines_in :
                        addr_reg[0] ? {8'h00, shared_addr_data_lines_in[15:8]} :
                                      {8'h00, shared_addr_data_lines_in[7:0]};

    // sequencer: address phase, data phase with wait, one turnaround cycle
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_reg <= ST_ADDR;
                        cnt_reg   <= 4'h0;
                    end
                end
                ST_ADDR:
                begin
                    if (to_data)
                    begin
                        state_reg <= ST_DATA;
                        cnt_reg   <= 4'h0;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ST_DATA:
                begin
                    if (data_wait)
                    begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    else if (ready_in)
                    begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    // one idle cycle so the lines are never driven from both sides
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // request fields are held for the whole cycle, except the width, which is ANDed with the pin as the data phase opens
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            write_reg <= 1'b0;
            wide_reg  <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 16'h0000;
        end
        else if (start)
        begin
            write_reg <= req_write;
            wide_reg  <= req_wide;
            addr_reg  <= req_addr;
            wdata_reg <= req_wdata;
        end
        else if (to_data)
        begin
            // a 16-bit cycle needs both the request and the width pin
            wide_reg <= mux_wide;
        end
    end

    // core handshake: both acknowledges are single-cycle pulses
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end
        else
        begin
            req_ready <= take_int | start;
            rsp_valid <= take_int | data_end;
            if (data_end && !write_reg)
            begin
                rsp_rdata <= rdata_next;
            end
        end
    end

    // shared lines: address first, then write data, or released for a read
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shared_addr_data_lines_out <= 16'h0000;
            shared_addr_data_lines_oe  <= 1'b0;
        end
        else if (start)
        begin
            shared_addr_data_lines_out <= lines_next;
            shared_addr_data_lines_oe  <= 1'b1;
        end
        else if (to_data)
        begin
            shared_addr_data_lines_out <= lines_next;
            shared_addr_data_lines_oe  <= write_reg;
        end
        else if (data_end)
        begin
            shared_addr_data_lines_oe  <= 1'b0;
        end
    end

    // strobes: valid spans the whole cycle, latch only the address phase
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_valid_n <= 1'b1;
            addr_latch   <= 1'b0;
            rd_n         <= 1'b1;
            wr_n         <= 1'b1;
        end
        else if (start)
        begin
            addr_valid_n <= 1'b0;
            // latch strobe rises only as a new cycle begins
            addr_latch   <= 1'b1;
        end
        else if (to_data)
        begin
            // the far side must hold its latched copy from here on
            addr_latch   <= 1'b0;
            rd_n         <= write_reg;
            wr_n         <= ~write_reg;
        end
        else if (data_end)
        begin
            addr_valid_n <= 1'b1;
            rd_n         <= 1'b1;
            wr_n         <= 1'b1;
        end
    end
endmodule // xbs_addr_strobes

// File: sim/xbs_properties.sv
`timescale 1ns/10ps
`include "xbs_consts.vh"
module xbs_props
(
    // core side
    input logic               sys_clk,
    input logic               rst_n,
    input logic               req_external,
    input logic [`XBS_AW-1:0] req_addr,
    input logic               req_ready,
    input logic               rsp_valid,
    // pins
    input logic [`XBS_DW-1:0] shared_addr_data_lines_out,
    input logic               shared_addr_data_lines_oe,
    input logic               addr_valid_n,
    input logic               addr_latch
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ext_strobe_a: assert property ($fell(addr_valid_n) |-> req_ready && $past(req_external))
        else $error("valid strobe on internal");
    addr_drive_a: assert property (addr_latch |-> shared_addr_data_lines_oe && !addr_valid_n
        && shared_addr_data_lines_out == $past(req_addr)) else $error("address not on lines");
    latch_start_a: assert property ($rose(addr_latch) |-> req_ready) else $error("latch late");
    latch_hold_a: assert property ($rose(addr_latch) |=> (!addr_latch && !rsp_valid) [*2])
        else $error("latch back early");
    valid_hold_a: assert property (!addr_valid_n |=> !addr_valid_n || rsp_valid)
        else $error("valid dropped early");
    valid_end_a: assert property (rsp_valid && !req_ready |-> $rose(addr_valid_n))
        else $error("valid not released");
    data_bound_a: assert property ($fell(addr_latch) |-> ##[2:20] rsp_valid)
        else $error("cycle too long");
    int_quiet_a: assert property (req_ready && rsp_valid |-> addr_valid_n && !addr_latch)
        else $error("internal strobe");
endmodule // xbs_props
bind xbs_addr_strobes xbs_props chk_i (.*);

// File: sim/xbs_mem_model.sv
`timescale 1ns/10ps
module xbs_mem_model
(
    // device pins
    input  logic        sys_clk,
    input  logic [15:0] pin_out,
    input  logic        pin_oe,
    input  logic        addr_latch,
    input  logic        rd_n,
    input  logic [3:0]  wait_cyc,
    output logic [15:0] pin_in,
    output logic        ready_in
);
    logic [15:0] addr_reg = 16'h0000;
    logic [15:0] last_reg = 16'h0000;
    int          cnt      = 0;
    always @(posedge sys_clk)
    begin
        last_reg <= pin_in;
        cnt      <= addr_latch ? 0 : cnt + 1;
        if (addr_latch)
            addr_reg <= pin_out;
    end
    // released lines toggle so a stale value never passes for data
    assign pin_in   = pin_oe ? pin_out : (!rd_n ? addr_reg ^ 16'h5A3C : ~last_reg);
    assign ready_in = cnt >= wait_cyc;
endmodule // xbs_mem_model

// File: sim/tb.sv
`timescale 1ns/10ps
`include "xbs_consts.vh"
module tb;
    logic        sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_external = 1'b0;
    logic        req_write = 1'b0, req_wide = 1'b0, bus_width_in = 1'b0;
    logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
    logic [3:0]  wait_cyc = 4'h0;
    wire  [15:0] rsp_rdata, pout, pin;
    wire         req_ready, rsp_valid, poe, addr_valid_n, addr_latch, rd_n, wr_n, ready_in;
    int          failures = 0, n_checks = 0;
    xbs_addr_strobes uut (.sys_clk, .rst_n, .req_valid, .req_external, .req_write, .req_wide,
        .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .bus_width_in, .ready_in,
        .shared_addr_data_lines_in(pin), .shared_addr_data_lines_out(pout),
        .shared_addr_data_lines_oe(poe), .addr_valid_n, .addr_latch, .rd_n, .wr_n);
    xbs_mem_model mem (.sys_clk, .pin_out(pout), .pin_oe(poe), .addr_latch, .rd_n, .wait_cyc,
        .pin_in(pin), .ready_in);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic complete_run;
    begin
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task automatic xfer(input logic e, w, wd, bw, input logic [15:0] a, d);
        logic [15:0] f, ws, as;
        int          n;
    begin
        f = a ^ 16'h5A3C;
        {req_valid, req_external, req_write, req_wide, bus_width_in} = {1'b1, e, w, wd, bw};
        {req_addr, req_wdata, ws, as} = {a, d, 16'h0000, 16'h0000};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1 n++;
            if (req_ready) req_valid = 1'b0;
            if (addr_latch) as = pout;
            if (!wr_n) ws = pout;
        end while (!rsp_valid && n < 40);
        if (!rsp_valid)
        begin
            failures++;
            complete_run();
        end
        if (e) chk(as, a);
        if (e && w) chk(ws, wd && bw ? d : {8'h00, a[0] ? d[15:8] : d[7:0]});
        if (e && !w) chk(rsp_rdata, wd && bw ? f : {8'h00, a[0] ? f[15:8] : f[7:0]});
        chk(16'(n >= 4), 16'(e));
        @(posedge sys_clk);
        #1;
    end
    endtask
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        void'($urandom(32'hc364));
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            if (i == 20)
            begin
                rst_n = 1'b0;
                @(posedge sys_clk);
                #1;
                chk(16'({addr_valid_n, addr_latch, poe, rd_n, wr_n}), 16'h0013);
                rst_n = 1'b1;
            end
            wait_cyc = (i < 16) ? 4'(i % 4) : 4'($urandom % 6);
            if (i < 16)
                xfer(i % 8 != 7, i[0], i[1], i[2], {15'h2AC9, i[3]}, 16'hC35A);
            else
                xfer($urandom % 4 != 0, $urandom, $urandom, $urandom, $urandom, $urandom);
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule // tb
